// File: core/apf_port.sv
// Asynchronous parallel byte FIFO port with its two byte buffers.
// Assumes the host paces every transfer with its strobes and obeys the flags;
// the chip side streams bytes in and out with valid/ready on ref_clk_i.
//
// What this block does
// - The port has a two-way eight-bit data bus, low-active read and write strobes and two low-active flags.
// - The data-available flag is high when nothing may be read and low when a byte waits in the outgoing buffer.
// - While the read strobe is low the current buffered byte is driven onto the data lines.
// - Each falling read strobe takes the next byte, if any, out of the outgoing buffer for presentation.
// - Each falling write strobe captures the byte on the data lines into the incoming buffer, unless that buffer is full.
// - The space-available flag is high when nothing may be written and low when the incoming buffer has room.
// - The data drive enable follows the read strobe itself, with no separate enable input.
// - The data-available flag rises when the read strobe returns high and falls again only when another byte is ready.
// - The space-available flag rises on every falling write strobe and falls again only if room remains.
// - After each read cycle the data-available flag stays high for at least 100 ns.
// - After each write cycle the space-available flag stays high for at least 100 ns.
`timescale 1ns/1ps

// Byte buffer with registered flags and occupancy
module apf_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic                     ref_clk_i,
	input  wire logic                     arst_n_i,
	// Fill side
	input  wire logic                     in_valid_i,
	input  wire logic [WIDTH-1:0]         in_data_i,
	output logic                          in_ready_o,
	// Drain side
	output logic                          out_valid_o,
	output logic [WIDTH-1:0]              out_data_o,
	input  wire logic                     out_ready_i,
	// Occupancy
	output logic [$clog2(DEPTH+1)-1:0]    level_o
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned LW = $clog2(DEPTH+1);

	// Refuse shapes the pointer wrap cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("apf_fifo: DEPTH must be a power of two, at least 2");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("apf_fifo: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [LW-1:0]    level_q;
	logic             ready_q;
	logic             valid_q;
	logic             push;
	logic             pop;
	logic [LW-1:0]    level_d;

	assign push = in_valid_i & ready_q;
	assign pop  = out_ready_i & valid_q;

	// Next occupancy from the push/pop pair
	always_comb begin
		level_d = level_q;
		if (push & ~pop)
			level_d = level_q + LW'(1);
		else if (pop & ~push)
			level_d = level_q - LW'(1);
	end

	// Storage write
	always_ff @(posedge ref_clk_i) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data_i;
	end

	// Pointers, count and flags
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q  <= '0;
			ready_q  <= 1'b1;
			valid_q  <= 1'b0;
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop)
				rd_ptr_q <= rd_ptr_q + AW'(1);
			level_q <= level_d;
			ready_q <= (level_d != LW'(DEPTH));
			valid_q <= (level_d != '0);
		end
	end

	// Handshake outputs come straight from their flops
	assign in_ready_o  = ready_q;
	assign out_valid_o = valid_q;
	assign out_data_o  = mem_q[rd_ptr_q];
	assign level_o     = level_q;

endmodule : apf_fifo

// Host-facing port: pins on one side, byte streams on the other
module apf_port
	import apf_pkg::*;
#(
	parameter int unsigned DATA_W = apf_pkg::DATA_W,
	parameter int unsigned DEPTH  = apf_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        arst_n_i,
	// Host pins
	input  wire logic                        rd_n_i,
	input  wire logic                        wr_n_i,
	input  wire logic [DATA_W-1:0]           data_i,
	output logic      [DATA_W-1:0]           data_o,
	output logic                             data_oe_o,
	output logic                             rx_avail_n_o,
	output logic                             tx_space_n_o,
	// Chip side, bytes going to the host
	input  wire logic                        to_host_valid_i,
	input  wire logic [DATA_W-1:0]           to_host_data_i,
	output logic                             to_host_ready_o,
	// Chip side, bytes coming from the host
	output logic                             from_host_valid_o,
	output logic      [DATA_W-1:0]           from_host_data_o,
	input  wire logic                        from_host_ready_i,
	// Buffer occupancy
	output logic      [$clog2(DEPTH+1)-1:0]  to_host_level_o,
	output logic      [$clog2(DEPTH+1)-1:0]  from_host_level_o
);
	import apf_pkg::*;

	// The pin carrier is fixed at the package width
	if (DATA_W != apf_pkg::DATA_W) begin : g_bad_data_w
		$error("apf_port: DATA_W must match the pin carrier width");
	end

	apf_pins_s      pin_meta_q;
	apf_pins_s      pin_sync_q;
	apf_pins_s      pin_prev_q;
	logic              rd_fall;
	logic              rd_rise;
	logic              wr_fall;
	logic              wr_rise;
	logic              th_valid;
	logic [DATA_W-1:0] th_data;
	logic              th_pop;
	logic              fh_ready;
	logic              fh_push;
	logic [DATA_W-1:0] data_q;
	logic              oe_q;
	logic              rx_n_q;
	logic              tx_n_q;
	logic [GAP_W-1:0]  rx_gap_q;
	logic [GAP_W-1:0]  tx_gap_q;

	// Two-flop synchroniser on strobes and data, then one stage for edges
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_meta_q <= PINS_IDLE;
			pin_sync_q <= PINS_IDLE;
			pin_prev_q <= PINS_IDLE;
		end else begin
			pin_meta_q <= '{rd_n: rd_n_i, wr_n: wr_n_i, data: data_i};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// Edge detection on the synchronised strobes only
	assign rd_fall = pin_prev_q.rd_n & ~pin_sync_q.rd_n;
	assign rd_rise = ~pin_prev_q.rd_n & pin_sync_q.rd_n;
	assign wr_fall = pin_prev_q.wr_n & ~pin_sync_q.wr_n;
	assign wr_rise = ~pin_prev_q.wr_n & pin_sync_q.wr_n;

	// Outgoing buffer, drained by host reads
	apf_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_to_host (
		.ref_clk_i   (ref_clk_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (to_host_valid_i),
		.in_data_i   (to_host_data_i),
		.in_ready_o  (to_host_ready_o),
		.out_valid_o (th_valid),
		.out_data_o  (th_data),
		.out_ready_i (th_pop),
		.level_o     (to_host_level_o)
	);

	// Incoming buffer, filled by host writes; a full buffer stalls the host via the flag
	apf_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_from_host (
		.ref_clk_i   (ref_clk_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (fh_push),
		.in_data_i   (pin_sync_q.data),
		.in_ready_o  (fh_ready),
		.out_valid_o (from_host_valid_o),
		.out_data_o  (from_host_data_o),
		.out_ready_i (from_host_ready_i),
		.level_o     (from_host_level_o)
	);

	// Read fetch and write capture, both on the strobe's falling edge
	assign th_pop  = rd_fall & th_valid;
	assign fh_push = wr_fall;

	// Presented byte: loaded when a read starts, held through the strobe
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			data_q <= '0;
		end else if (th_pop) begin
			data_q <= th_data;
		end
	end

	// Drive enable follows the synchronised read strobe
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= ~pin_sync_q.rd_n;
		end
	end

	// Read-side idle timer, started when the read strobe returns high
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_gap_q <= '0;
		end else if (rd_rise) begin
			rx_gap_q <= GAP_W'(RX_GAP_CYC);
		end else if (rx_gap_q != '0) begin
			rx_gap_q <= rx_gap_q - GAP_W'(1);
		end
	end

	// Data-available flag: high on read end, low again once a byte waits
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_n_q <= FLAG_IDLE;
		end else if (rd_rise) begin
			rx_n_q <= 1'b1;
		end else if (pin_sync_q.rd_n && rx_gap_q == '0) begin
			rx_n_q <= ~th_valid;
		end
	end

	// Write-side idle timer, started when the write strobe returns high
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_gap_q <= '0;
		end else if (wr_rise) begin
			tx_gap_q <= GAP_W'(TX_GAP_CYC);
		end else if (tx_gap_q != '0) begin
			tx_gap_q <= tx_gap_q - GAP_W'(1);
		end
	end

	// Space-available flag: high on every write start, low again only with room
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_n_q <= FLAG_IDLE;
		end else if (wr_fall) begin
			tx_n_q <= 1'b1;
		end else if (pin_sync_q.wr_n && !wr_rise && tx_gap_q == '0) begin
			tx_n_q <= ~fh_ready;
		end
	end

	// Pin outputs straight from flops
	assign data_o       = data_q;
	assign data_oe_o    = oe_q;
	assign rx_avail_n_o = rx_n_q;
	assign tx_space_n_o = tx_n_q;

endmodule : apf_port

// File: core/apf_pkg.sv
// Shared constants and carriers for the asynchronous parallel byte FIFO port.
// Assumes a single 10 MHz system clock; the host strobes are unrelated to it.
package apf_pkg;

	// Bus width and buffer depth defaults
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned FIFO_DEPTH = 8;

	// System clock rate and strobe-to-flag minimum idle times
	localparam int unsigned CLK_KHZ       = 10000;
	localparam int unsigned RX_GAP_NS     = 100;
	localparam int unsigned TX_GAP_NS     = 100;
	localparam int unsigned RX_GAP_CYC_RAW = (RX_GAP_NS * CLK_KHZ + 999999) / 1000000;
	localparam int unsigned TX_GAP_CYC_RAW = (TX_GAP_NS * CLK_KHZ + 999999) / 1000000;
	localparam int unsigned RX_GAP_CYC = (RX_GAP_CYC_RAW < 1) ? 1 : RX_GAP_CYC_RAW;
	localparam int unsigned TX_GAP_CYC = (TX_GAP_CYC_RAW < 1) ? 1 : TX_GAP_CYC_RAW;
	localparam int unsigned GAP_W      = 4;

	// Reset levels of the pin-side flops
	localparam logic FLAG_IDLE   = 1'b1;
	localparam logic STROBE_IDLE = 1'b1;

	// Host pin sample carried through the synchroniser as one bundle
	typedef struct packed {
		logic              rd_n;
		logic              wr_n;
		logic [DATA_W-1:0] data;
	} apf_pins_s;

	localparam apf_pins_s PINS_IDLE = '{rd_n: STROBE_IDLE, wr_n: STROBE_IDLE, data: '0};

endpackage : apf_pkg

// File: dv/apf_port_monitor.sv
// Checker for the host pins, flags and buffer levels of the FIFO port.
// Assumes it is bound to apf_port and that everything runs on one clock.
`timescale 1ns/1ps
module apf_port_monitor #(
	parameter int unsigned DEPTH = 8
) (
	// Clock, reset and host pins
	input wire logic                       ref_clk_i,
	input wire logic                       arst_n_i,
	input wire logic                       rd_n_i,
	input wire logic                       wr_n_i,
	input wire logic                       data_oe_o,
	input wire logic                       rx_avail_n_o,
	input wire logic                       tx_space_n_o,
	// Occupancy
	input wire logic [$clog2(DEPTH+1)-1:0] to_host_level_o,
	input wire logic [$clog2(DEPTH+1)-1:0] from_host_level_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Strobe falls that are held low at the next edge
	sequence s_rd_fall; $fell(rd_n_i) ##1 !rd_n_i; endsequence
	sequence s_wr_fall; $fell(wr_n_i) ##1 !wr_n_i; endsequence
	property p_oe_cause; $rose(data_oe_o) |-> !$past(rd_n_i, 2); endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("drive enable rose without a low read strobe");
	property p_oe_drive; s_rd_fall |-> ##[1:3] data_oe_o; endproperty
	a_oe_drive: assert property (p_oe_drive)
		else $error("read byte not driven after read strobe fell");
	property p_release; rd_n_i [*3] |=> !data_oe_o; endproperty
	a_release: assert property (p_release)
		else $error("data lines still driven with read strobe high");
	property p_rx_rise; $fell(data_oe_o) |-> rx_avail_n_o; endproperty
	a_rx_rise: assert property (p_rx_rise)
		else $error("data flag not raised at end of read");
	property p_rx_gap; $rose(rx_avail_n_o) |=> rx_avail_n_o; endproperty
	a_rx_gap: assert property (p_rx_gap)
		else $error("data flag low again too soon");
	property p_rx_data; $fell(rx_avail_n_o) |-> to_host_level_o != 0; endproperty
	a_rx_data: assert property (p_rx_data)
		else $error("data flag low with empty outgoing buffer");
	property p_tx_rise; s_wr_fall |-> ##[1:3] tx_space_n_o; endproperty
	a_tx_rise: assert property (p_tx_rise)
		else $error("space flag not raised after write strobe fell");
	property p_tx_gap; $rose(wr_n_i) |-> tx_space_n_o [*4]; endproperty
	a_tx_gap: assert property (p_tx_gap)
		else $error("space flag low again too soon");
	property p_tx_room; $fell(tx_space_n_o) |-> from_host_level_o < DEPTH; endproperty
	a_tx_room: assert property (p_tx_room)
		else $error("space flag low with full incoming buffer");
endmodule : apf_port_monitor
bind apf_port apf_port_monitor #(.DEPTH(DEPTH)) i_apf_port_monitor (
	.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
	.data_oe_o(data_oe_o), .rx_avail_n_o(rx_avail_n_o), .tx_space_n_o(tx_space_n_o),
	.to_host_level_o(to_host_level_o), .from_host_level_o(from_host_level_o));

// File: dv/apf_host.sv
// Host model: strobes reads and writes and resolves the shared data bus.
// Assumes the port drives the bus only while its drive enable is high.
`timescale 1ns/1ps
module apf_host (
	// Clock and port pins
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] dev_data_i,
	input  wire logic       dev_oe_i,
	input  wire logic       rx_n_i,
	input  wire logic       tx_n_i,
	output logic            rd_n_o = 1'b1,
	output logic            wr_n_o = 1'b1,
	output logic      [7:0] bus_o
);
	logic [7:0] drv_q = 8'h00;
	logic       own_q = 1'b0;
	// Wire level: port, host, or a float that flips
	assign bus_o = dev_oe_i ? dev_data_i : (own_q ? drv_q : ~drv_q);
	// One strobe cycle; ok stays low if the flag never allowed it
	task automatic xfer(input bit wr, input logic [7:0] wd, output logic [7:0] rd, output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		rd = 8'h00;
		while ((wr ? tx_n_i : rx_n_i) !== 1'b0) begin
			if (n == 50) return;
			n++;
			@(negedge ref_clk_i);
		end
		drv_q = wd;
		own_q = wr;
		if (wr) wr_n_o = 1'b0;
		else rd_n_o = 1'b0;
		repeat (5) @(negedge ref_clk_i);
		rd = bus_o;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		own_q = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		ok = 1'b1;
	endtask : xfer
endmodule : apf_host

// File: dv/test_apf_port.sv
// Self-checking bench for the parallel FIFO port and its buffers.
// Assumes the host model and the bound checker of this folder.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("unexpected %s: expected %0h seen %0h", what, exp, got); \
		end \
	end
module test_apf_port;
	import apf_pkg::*;
	typedef struct packed {
		logic [7:0] out_b;
		logic [7:0] in_b;
	} apf_row_s;
	localparam apf_row_s ROWS [3] = '{'{8'h00, 8'hFF}, '{8'hA5, 8'h5A}, '{8'h80, 8'h01}};
	logic       clk = 1'b0, rst_n = 1'b0, thv = 1'b0, fhr = 1'b0;
	logic [7:0] thd = 8'h00, din, dout, fhd, b;
	logic       rd_n, wr_n, oe, rxn, txn, thr, fhv;
	logic [3:0] thl, fhl;
	bit         ok;
	int         n_fail = 0, comparisons = 0;
	// System clock, 100 ns period
	always #50 clk = ~clk;
	apf_port i_apf_port (.ref_clk_i(clk), .arst_n_i(rst_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.data_i(din), .data_o(dout), .data_oe_o(oe), .rx_avail_n_o(rxn), .tx_space_n_o(txn),
		.to_host_valid_i(thv), .to_host_data_i(thd), .to_host_ready_o(thr),
		.from_host_valid_o(fhv), .from_host_data_o(fhd), .from_host_ready_i(fhr),
		.to_host_level_o(thl), .from_host_level_o(fhl));
	apf_host i_apf_host (.ref_clk_i(clk), .dev_data_i(dout), .dev_oe_i(oe), .rx_n_i(rxn),
		.tx_n_i(txn), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(din));
	// Chip side push and pop, one byte each
	task automatic push(input logic [7:0] v);
		int n;
		n = 0;
		thv = 1'b1;
		thd = v;
		while (thr !== 1'b1 && n++ < 20) @(negedge clk);
		@(negedge clk);
		thv = 1'b0;
		// One idle edge so back-to-back pushes never retoggle valid in one step
		@(negedge clk);
		if (n > 20) begin
			n_fail++;
			summarize();
		end
	endtask : push
	task automatic pop(output logic [7:0] v);
		int n;
		n = 0;
		while (fhv !== 1'b1 && n++ < 20) @(negedge clk);
		v = fhd;
		fhr = 1'b1;
		@(negedge clk);
		fhr = 1'b0;
		// One idle edge so back-to-back pops never retoggle ready in one step
		@(negedge clk);
		if (n > 20) begin
			n_fail++;
			summarize();
		end
	endtask : pop
	task automatic summarize();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// Main sequence: rows first, then fills, refusals and a second reset
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		`CHK("oe", 1'b0, oe)
		`CHK("rx flag", 1'b1, rxn)
		repeat (4) @(negedge clk);
		`CHK("tx flag", 1'b0, txn)
		foreach (ROWS[i]) begin
			push(ROWS[i].out_b);
			i_apf_host.xfer(1'b0, 8'h00, b, ok);
			`CHK("read ok", 1'b1, ok)
			`CHK("read byte", ROWS[i].out_b, b)
			`CHK("rx flag", 1'b1, rxn)
			i_apf_host.xfer(1'b1, ROWS[i].in_b, b, ok);
			`CHK("write ok", 1'b1, ok)
			pop(b);
			`CHK("written byte", ROWS[i].in_b, b)
		end
		for (int i = 0; i < 8; i++) begin
			i_apf_host.xfer(1'b1, 8'(i * 17), b, ok);
			`CHK("fill ok", 1'b1, ok)
		end
		`CHK("in level", 4'h8, fhl)
		`CHK("tx flag full", 1'b1, txn)
		i_apf_host.xfer(1'b1, 8'hEE, b, ok);
		`CHK("write refused", 1'b0, ok)
		for (int i = 0; i < 8; i++) begin
			pop(b);
			`CHK("drain", 8'(i * 17), b)
		end
		for (int i = 0; i < 8; i++) push(8'(240 - i));
		`CHK("chip ready", 1'b0, thr)
		for (int i = 0; i < 8; i++) begin
			i_apf_host.xfer(1'b0, 8'h00, b, ok);
			`CHK("burst ok", 1'b1, ok)
			`CHK("burst read", 8'(240 - i), b)
		end
		i_apf_host.xfer(1'b0, 8'h00, b, ok);
		`CHK("read refused", 1'b0, ok)
		push(8'h3C);
		rst_n = 1'b0;
		@(negedge clk);
		`CHK("level after reset", 4'h0, thl)
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("rx after reset", 1'b1, rxn)
		summarize();
	end
endmodule : test_apf_port
